// File: ddtm_pkg.sv
// shared constants, types and timing counts of the command timing guard
// assumes a single 250 MHz command clock shared with the memory controller
// Functional notes
// - 15 ns write recovery; auto-precharge closes the bank when recovery ends, then precharge time runs
// - mode register bit 12 picks fast or slow active power-down exit
// - calibration drive mode drives outputs within 0 to 12 ns; the core enables them 4 cycles (16 ns) after the command
// - strobe differential or single-ended per extended mode enable bit
`default_nettype none
package ddtm_pkg;
  localparam int CLK_PS = 4000;
  localparam int RRD_PS = 10000;
  localparam int FAW_PS = 45000;
  localparam int WR_PS = 15000;
  localparam int WTR_PS = 7500;
  localparam int RTP_PS = 7500;
  localparam int RFC_PS = 127500;
  localparam int XSNR_EXTRA_PS = 10000;
  localparam int RP_PS = 13125;
  localparam int OIT_MAX_PS = 12000;

  function automatic int ceil_cyc(input int ps);
    return (ps + CLK_PS - 1) / CLK_PS;
  endfunction

  function automatic int at_least_one(input int n);
    return (n < 1) ? 1 : n;
  endfunction

  localparam logic [7:0] RRD_CYC = 8'((ceil_cyc(RRD_PS) < 2) ? 2 : ceil_cyc(RRD_PS));
  localparam logic [7:0] FAW_CYC = 8'(ceil_cyc(FAW_PS));
  localparam logic [7:0] CCD_CYC = 8'h02;
  localparam logic [7:0] WR_CYC = 8'(ceil_cyc(WR_PS));
  localparam logic [7:0] WTR_CYC = 8'(ceil_cyc(WTR_PS));
  localparam logic [7:0] RTP_CYC = 8'(ceil_cyc(RTP_PS));
  localparam logic [7:0] XSNR_CYC = 8'(ceil_cyc(RFC_PS + XSNR_EXTRA_PS));
  localparam logic [7:0] XSRD_CYC = 8'hC8;
  localparam logic [7:0] XP_CYC = 8'h03;
  localparam logic [7:0] XARD_CYC = 8'h03;
  localparam logic [7:0] XARDS_BASE = 8'h0A;
  localparam logic [7:0] CKE_CYC = 8'h03;
  localparam logic [7:0] ANPD_CYC = 8'h04;
  localparam logic [7:0] AXPD_CYC = 8'h0B;
  localparam logic [7:0] RP_CYC = 8'(ceil_cyc(RP_PS));
  localparam logic [7:0] OIT_CYC = 8'(at_least_one(OIT_MAX_PS / CLK_PS));

  // mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int MR_SLOW_EXIT_BIT = 12;
  localparam int EMR_AL_LSB = 3;
  localparam int EMR_OCD_LSB = 7;
  localparam int EMR_DQS_OFF_BIT = 10;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] OCD_DRIVE1 = 3'h1;
  localparam logic [2:0] OCD_DRIVE0 = 3'h2;

  localparam logic [2:0] RST_AL = 3'h0;
  localparam logic [2:0] RST_CL = 3'h3;
  localparam logic [2:0] RST_OCD = 3'h0;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_EXTENDED_MODE_SET, CMD_REF, CMD_SREF, CMD_PDE, CMD_EXIT,
    CMD_PRE, CMD_ACT, CMD_WR, CMD_RD
  } ddtm_cmd_e;

  typedef enum logic [1:0] {PW_ON, PW_SREF, PW_PPD, PW_APD} ddtm_pwr_e;

  typedef struct packed {
    ddtm_cmd_e cmd;
    logic [2:0] ba;
    logic a10;
    logic cke;
    logic odt;
    logic [2:0] al;
    logic [2:0] cl;
    logic bl8;
    logic slow_exit;
    logic dqs_single;
    logic [2:0] ocd;
  } ddtm_dec_s;

  typedef struct packed {
    ddtm_pwr_e pwr;
    logic [7:0] bank_open;
    logic [7:0] int_pre;
    logic [7:0][7:0] ap_cnt;
    logic [7:0][7:0] rp_cnt;
    logic [3:0][7:0] faw;
    logic [7:0] act_gap;
    logic [7:0] col_gap;
    logic [7:0] wtr;
    logic [7:0] rtp;
    logic [7:0] wrec;
    logic [7:0] xs_nonread;
    logic [7:0] xs_read;
    logic [7:0] cke_cnt;
    logic [7:0] odt_cnt;
    logic [7:0] axpd;
    logic [7:0] cal_cnt;
    logic odt_prev;
    logic cal_level;
    logic cal_oe_n;
    logic viol;
  } ddtm_core_s;
endpackage
`default_nettype wire

// File: ddtm_cmd_if.sv
// decoded command and live mode settings passed from decoder to timing core
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface ddtm_cmd_if;
  import ddtm_pkg::*;
  ddtm_cmd_e cmd;
  logic [2:0] ba;
  logic a10;
  logic cke;
  logic odt;
  logic [2:0] al;
  logic [2:0] cl;
  logic bl8;
  logic slow_exit;
  logic dqs_single;
  logic [2:0] ocd;
  modport dec (output cmd, ba, a10, cke, odt, al, cl, bl8, slow_exit, dqs_single, ocd);
  modport core (input cmd, ba, a10, cke, odt, al, cl, bl8, slow_exit, dqs_single, ocd);
endinterface
`default_nettype wire

// File: ddtm_cmd_decode.sv
// command pin decoder and mode register holder
// assumes command pins come from controller logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module ddtm_cmd_decode (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  input wire logic i_odt,
  ddtm_cmd_if.dec bus
);
  import ddtm_pkg::*;
  ddtm_dec_s q, d;

  always_comb begin
    d = q;
    d.cmd = CMD_NOP;
    d.ba = i_ba;
    d.a10 = i_addr[10];
    d.cke = i_cke;
    d.odt = i_odt;
    if (q.cke && !i_cke) begin
      // enable falling with refresh selected means self refresh, else power-down
      d.cmd = (!i_cs_n && !i_ras_n && !i_cas_n && i_we_n) ? CMD_SREF : CMD_PDE;
    end else if (!q.cke && i_cke) begin
      d.cmd = CMD_EXIT;
    end else if (q.cke && !i_cs_n) begin
      case ({i_ras_n, i_cas_n, i_we_n})
        3'h0: begin
          if (i_ba == 3'h0) begin
            d.cmd = CMD_MRS;
            d.bl8 = (i_addr[MR_BL_LSB +: 3] == BL_CODE_8);
            d.cl = i_addr[MR_CL_LSB +: 3];
            d.slow_exit = i_addr[MR_SLOW_EXIT_BIT];
          end else if (i_ba == 3'h1) begin
            d.cmd = CMD_EXTENDED_MODE_SET;
            d.al = i_addr[EMR_AL_LSB +: 3];
            d.ocd = i_addr[EMR_OCD_LSB +: 3];
            d.dqs_single = i_addr[EMR_DQS_OFF_BIT];
          end else begin
            d.cmd = CMD_NOP;
          end
        end
        3'h1: d.cmd = CMD_REF;
        3'h2: d.cmd = CMD_PRE;
        3'h3: d.cmd = CMD_ACT;
        3'h4: d.cmd = CMD_WR;
        3'h5: d.cmd = CMD_RD;
        default: d.cmd = CMD_NOP;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q <= '{cmd: CMD_NOP, ba: 3'h0, a10: 1'b0, cke: 1'b0, odt: 1'b0, al: RST_AL, cl: RST_CL,
             bl8: 1'b0, slow_exit: 1'b0, dqs_single: 1'b0, ocd: RST_OCD};
    end else begin
      q <= d;
    end
  end

  assign bus.cmd = q.cmd;
  assign bus.ba = q.ba;
  assign bus.a10 = q.a10;
  assign bus.cke = q.cke;
  assign bus.odt = q.odt;
  assign bus.al = q.al;
  assign bus.cl = q.cl;
  assign bus.bl8 = q.bl8;
  assign bus.slow_exit = q.slow_exit;
  assign bus.dqs_single = q.dqs_single;
  assign bus.ocd = q.ocd;

  AST_SLOW_EXIT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (q.cke && i_cke && !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n && i_ba == 3'h0)
      |=> (bus.slow_exit == $past(i_addr[MR_SLOW_EXIT_BIT])) && bus.cmd == CMD_MRS)
    else $error("exit speed bit not taken from mode set");
  AST_DQS_MODE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (bus.cmd != CMD_EXTENDED_MODE_SET) |-> (bus.dqs_single == $past(bus.dqs_single)) or $past(i_reset))
    else $error("strobe mode changed without extended mode set");
endmodule
`default_nettype wire

// File: ddtm_timing_core.sv
// command timing guard of the memory device: bank state, auto-precharge,
// power-state exit timers, calibration drive and strobe mode
// assumes the controller drives pins synchronously to i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module ddtm_timing_core (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  input wire logic i_odt,
  output logic o_violation,
  output logic [7:0] o_bank_open,
  output logic [7:0] o_int_precharge,
  output logic o_slow_exit,
  output logic o_dqs_single_ended,
  output logic o_cal_drive_level,
  output logic o_cal_drive_oe_n,
  output logic o_odt_sync_ok,
  output logic o_self_refresh,
  output logic o_power_down
);
  import ddtm_pkg::*;

  ddtm_cmd_if c ();
  ddtm_core_s q, d;

  ddtm_cmd_decode u_dec (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_cke(i_cke),
    .i_cs_n(i_cs_n),
    .i_ras_n(i_ras_n),
    .i_cas_n(i_cas_n),
    .i_we_n(i_we_n),
    .i_ba(i_ba),
    .i_addr(i_addr),
    .i_odt(i_odt),
    .bus(c)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] dec8(input logic [7:0] x);
    return (x == 8'h00) ? 8'h00 : x - 8'h01;
  endfunction

  // cycles from a write command to the end of its data burst
  function automatic logic [7:0] wr_end(input logic [2:0] al, input logic [2:0] cl, input logic bl8);
    return 8'(al) + 8'(cl) - 8'h01 + (bl8 ? 8'h04 : 8'h02);
  endfunction

  function automatic logic [7:0] rd_to_pre(input logic [2:0] al, input logic bl8);
    logic [7:0] n;
    n = 8'(al) + (bl8 ? 8'h04 : 8'h02);
    return (n < RTP_CYC) ? RTP_CYC : n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic faw_full;
  logic bad;
  logic placed;

  always_comb begin
    d = q;
    bad = 1'b0;
    placed = 1'b0;
    faw_full = (q.faw[0] != 8'h00) && (q.faw[1] != 8'h00) && (q.faw[2] != 8'h00) && (q.faw[3] != 8'h00);
    d.int_pre = 8'h00;
    d.act_gap = dec8(q.act_gap);
    d.col_gap = dec8(q.col_gap);
    d.wtr = dec8(q.wtr);
    d.rtp = dec8(q.rtp);
    d.wrec = dec8(q.wrec);
    d.xs_nonread = dec8(q.xs_nonread);
    d.xs_read = dec8(q.xs_read);
    d.cke_cnt = dec8(q.cke_cnt);
    d.odt_cnt = dec8(q.odt_cnt);
    d.axpd = dec8(q.axpd);
    d.cal_cnt = dec8(q.cal_cnt);
    for (int i = 0; i < 4; i++) begin
      d.faw[i] = dec8(q.faw[i]);
    end
    for (int b = 0; b < 8; b++) begin
      d.ap_cnt[b] = dec8(q.ap_cnt[b]);
      d.rp_cnt[b] = dec8(q.rp_cnt[b]);
      // internal precharge fires once the auto-precharge delay runs out
      if (q.ap_cnt[b] == 8'h01) begin
        d.int_pre[b] = 1'b1;
        d.bank_open[b] = 1'b0;
        d.rp_cnt[b] = RP_CYC - 8'h01;
      end
    end
    if (q.cal_cnt == 8'h01) begin
      d.cal_oe_n = 1'b0;
    end
    d.odt_prev = c.odt;
    if (c.odt != q.odt_prev) begin
      d.odt_cnt = ANPD_CYC - 8'h01;
    end

    case (c.cmd)
      CMD_ACT: begin
        bad = (q.act_gap != 8'h00) || faw_full || (q.rp_cnt[c.ba] != 8'h00)
              || (q.xs_nonread != 8'h00) || q.bank_open[c.ba];
        d.bank_open[c.ba] = 1'b1;
        d.act_gap = RRD_CYC - 8'h01;
        for (int i = 0; i < 4; i++) begin
          if (!placed && q.faw[i] == 8'h00) begin
            d.faw[i] = FAW_CYC - 8'h01;
            placed = 1'b1;
          end
        end
      end
      CMD_WR: begin
        bad = (q.col_gap != 8'h00) || !q.bank_open[c.ba] || (q.xs_nonread != 8'h00);
        d.col_gap = CCD_CYC - 8'h01;
        d.wtr = wr_end(c.al, c.cl, c.bl8) + WTR_CYC - 8'h01;
        d.wrec = wr_end(c.al, c.cl, c.bl8) + WR_CYC - 8'h01;
        if (c.a10) begin
          // precharge lands after recovery, so the bank reopens after recovery plus precharge
          d.ap_cnt[c.ba] = wr_end(c.al, c.cl, c.bl8) + WR_CYC;
        end
      end
      CMD_RD: begin
        bad = (q.col_gap != 8'h00) || !q.bank_open[c.ba] || (q.wtr != 8'h00)
              || (q.xs_read != 8'h00);
        d.col_gap = CCD_CYC - 8'h01;
        d.rtp = rd_to_pre(c.al, c.bl8) - 8'h01;
        if (c.a10) begin
          d.ap_cnt[c.ba] = rd_to_pre(c.al, c.bl8);
        end
      end
      CMD_PRE: begin
        bad = (q.rtp != 8'h00) || (q.wrec != 8'h00) || (q.xs_nonread != 8'h00);
        for (int b = 0; b < 8; b++) begin
          if ((c.a10 || c.ba == 3'(b)) && q.bank_open[b]) begin
            d.bank_open[b] = 1'b0;
            d.rp_cnt[b] = RP_CYC - 8'h01;
          end
        end
      end
      CMD_REF, CMD_MRS: begin
        bad = (q.xs_nonread != 8'h00) || (q.bank_open != 8'h00);
      end
      CMD_EXTENDED_MODE_SET: begin
        bad = (q.xs_nonread != 8'h00);
        if (c.ocd == OCD_DRIVE1 || c.ocd == OCD_DRIVE0) begin
          d.cal_level = (c.ocd == OCD_DRIVE1);
          d.cal_cnt = OIT_CYC;
          d.cal_oe_n = 1'b1;
        end else begin
          d.cal_cnt = 8'h00;
          d.cal_oe_n = 1'b1;
        end
      end
      CMD_SREF, CMD_PDE: begin
        bad = (q.cke_cnt != 8'h00) || (q.odt_cnt != 8'h00);
        d.cke_cnt = CKE_CYC - 8'h01;
        if (c.cmd == CMD_SREF) begin
          d.pwr = PW_SREF;
        end else begin
          d.pwr = (q.bank_open != 8'h00) ? PW_APD : PW_PPD;
        end
      end
      CMD_EXIT: begin
        bad = (q.cke_cnt != 8'h00);
        d.cke_cnt = CKE_CYC - 8'h01;
        d.axpd = AXPD_CYC - 8'h01;
        d.pwr = PW_ON;
        case (q.pwr)
          PW_SREF: begin
            d.xs_nonread = XSNR_CYC - 8'h01;
            d.xs_read = XSRD_CYC - 8'h01;
          end
          PW_PPD: d.xs_nonread = XP_CYC - 8'h01;
          PW_APD: begin
            // slow exit trades wake-up latency for lower standby power
            d.xs_read = c.slow_exit ? (XARDS_BASE - 8'(c.al) - 8'h01) : (XARD_CYC - 8'h01);
          end
          default: d.pwr = PW_ON;
        endcase
      end
      default: bad = 1'b0;
    endcase
    d.viol = bad;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q <= '{pwr: PW_ON, bank_open: 8'h00, int_pre: 8'h00, ap_cnt: '0, rp_cnt: '0, faw: '0,
             act_gap: 8'h00, col_gap: 8'h00, wtr: 8'h00, rtp: 8'h00, wrec: 8'h00,
             xs_nonread: 8'h00, xs_read: 8'h00, cke_cnt: 8'h00, odt_cnt: 8'h00, axpd: 8'h00,
             cal_cnt: 8'h00, odt_prev: 1'b0, cal_level: 1'b0, cal_oe_n: 1'b1, viol: 1'b0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_violation = q.viol;
  assign o_bank_open = q.bank_open;
  assign o_int_precharge = q.int_pre;
  assign o_slow_exit = c.slow_exit;
  assign o_dqs_single_ended = c.dqs_single;
  assign o_cal_drive_level = q.cal_level;
  assign o_cal_drive_oe_n = q.cal_oe_n;
  assign o_odt_sync_ok = (q.axpd == 8'h00);
  assign o_self_refresh = (q.pwr == PW_SREF);
  assign o_power_down = (q.pwr == PW_PPD) || (q.pwr == PW_APD);

  AST_ACT_GAP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_ACT && q.act_gap != 8'h00) |=> o_violation)
    else $error("activate inside activate gap not flagged");
  AST_FAW: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_ACT && q.faw[0] != 8'h00 && q.faw[1] != 8'h00 && q.faw[2] != 8'h00
      && q.faw[3] != 8'h00) |=> o_violation)
    else $error("fifth activate in window not flagged");
  AST_COL_GAP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ((c.cmd == CMD_RD || c.cmd == CMD_WR) ##1 (c.cmd == CMD_RD || c.cmd == CMD_WR)) |=> o_violation)
    else $error("back to back column commands not flagged");
  AST_AP_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_WR && c.a10 && q.ap_cnt[c.ba] == 8'h00 && c.cl == 3'h3 && c.al == 3'h0 && !c.bl8)
      |-> ##9 o_int_precharge[$past(c.ba, 9)])
    else $error("write auto-precharge not at recovery end");
  AST_WTR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_WR ##1 c.cmd == CMD_RD) |=> o_violation)
    else $error("read right after write not flagged");
  AST_SREF_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_EXIT && q.pwr == PW_SREF) |=> (q.xs_read == XSRD_CYC - 8'h01) ##1 !o_self_refresh)
    else $error("self refresh exit read timer not loaded");
  AST_CKE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ((c.cmd == CMD_PDE || c.cmd == CMD_SREF) ##1 c.cmd == CMD_EXIT) |=> o_violation)
    else $error("short clock enable pulse not flagged");
  AST_CAL_DRIVE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (c.cmd == CMD_EXTENDED_MODE_SET && c.ocd == OCD_DRIVE0) ##1 (c.cmd != CMD_EXTENDED_MODE_SET) [*3] |=> !o_cal_drive_oe_n)
    else $error("calibration drive not enabled within delay");
endmodule
`default_nettype wire

// File: ddtm_host_model.sv
// behavioural host controller driving the command pins of the timing guard
// assumes the bench calls its tasks from the falling edge of i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module ddtm_host_model (
  input wire logic i_clk_sys,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [2:0] o_ba,
  output logic [13:0] o_addr,
  output logic o_odt
);
  int ecnt = 0;
  int last = -100;
  int cke_last = -100;

  // the clock never stops here, so the hold after an enable drop is always met
  always @(posedge i_clk_sys) ecnt <= ecnt + 1;

  initial begin
    o_cke = 1'b0;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_ba = 3'h0;
    o_addr = 14'h0000;
    o_odt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // deselect cycles until the requested spacing in whole cycles has passed
  task automatic wait_gap(input int gap);
    while (ecnt + 1 - last < gap) @(negedge i_clk_sys);
  endtask

  // released address lines are inverted so a stale value is never held
  task automatic deselect();
    @(negedge i_clk_sys);
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
    o_addr = ~o_addr;
    o_ba = ~o_ba;
  endtask

  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] addr, input int gap);
    wait_gap(gap);
    {o_ras_n, o_cas_n, o_we_n} = rcw;
    o_cs_n = 1'b0;
    o_ba = ba;
    o_addr = addr;
    last = ecnt + 1;
    deselect();
  endtask

  // short_ok lets the bench break the minimum pulse on purpose
  task automatic set_cke(input logic lvl, input logic sref, input int gap, input logic short_ok);
    if (!short_ok) begin
      while (ecnt + 1 - cke_last < 3) @(negedge i_clk_sys);
    end
    wait_gap(gap);
    o_cke = lvl;
    if (sref) begin
      o_cs_n = 1'b0;
      {o_ras_n, o_cas_n, o_we_n} = 3'h1;
    end
    last = ecnt + 1;
    cke_last = ecnt + 1;
    deselect();
  endtask

  task automatic set_odt(input logic lvl, input int gap);
    wait_gap(gap);
    o_odt = lvl;
    last = ecnt + 1;
    @(negedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// File: ddtm_timing_core_tb.sv
// self-checking bench of the command timing guard with a host model
// assumes the package timing counts at a 4 ns command clock
`timescale 1ns/10ps
`default_nettype none
module ddtm_timing_core_tb;
  import ddtm_pkg::*;
  localparam logic [2:0] K_MRS = 3'h0;
  localparam logic [2:0] K_PRE = 3'h2;
  localparam logic [2:0] K_ACT = 3'h3;
  localparam logic [2:0] K_WR = 3'h4;
  localparam logic [2:0] K_RD = 3'h5;
  // write data end with the reset mode: additive 0, latency 3, burst 4
  localparam int WEND = 0 + 3 - 1 + 2;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0] ba;
  logic [13:0] addr;
  logic o_violation, o_slow_exit, o_dqs_single_ended, o_cal_drive_level;
  logic o_cal_drive_oe_n, o_odt_sync_ok, o_self_refresh, o_power_down;
  logic [7:0] o_bank_open, o_int_precharge;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h4c2140ad;
  int k;
  logic [2:0] ocd;
  logic q;

  initial forever #2 i_clk_sys = ~i_clk_sys;

  ddtm_host_model ddtm_host_model_inst (.i_clk_sys(i_clk_sys), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr), .o_odt(odt));

  ddtm_timing_core ddtm_timing_core_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_odt(odt),
    .o_violation(o_violation), .o_bank_open(o_bank_open), .o_int_precharge(o_int_precharge),
    .o_slow_exit(o_slow_exit), .o_dqs_single_ended(o_dqs_single_ended), .o_cal_drive_level(o_cal_drive_level),
    .o_cal_drive_oe_n(o_cal_drive_oe_n), .o_odt_sync_ok(o_odt_sync_ok), .o_self_refresh(o_self_refresh),
    .o_power_down(o_power_down));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // called one negedge after the sampling edge; the verdict is registered at the next edge
  // and stands for that cycle only, so look at the negedge right after it
  task automatic settle2();
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask

  function automatic int slack();
    return $unsigned($random(seed)) % 3;
  endfunction

  // second command at one cycle short of the limit, or at or past it
  task automatic pair(input logic [2:0] c1, input logic [2:0] c2, input int lim, input bit same, input bit bad);
    logic [2:0] b;
    b = 3'($random(seed));
    if (c1 != K_ACT) ddtm_host_model_inst.issue(K_ACT, b, 14'($random(seed)), 12);
    ddtm_host_model_inst.issue(c1, b, 14'($random(seed)) & 14'h3BFF, 8);
    ddtm_host_model_inst.issue(c2, same ? b : b ^ 3'h1, 14'($random(seed)) & 14'h3BFF,
      bad ? lim - 1 : lim + slack());
    settle2();
    check(o_violation, bad, "spacing");
    ddtm_host_model_inst.issue(K_PRE, 3'h0, 14'h0400, 12);
  endtask

  task automatic pdx(input bit sref, input bit open, input bit slow, input logic [2:0] c2, input int lim);
    for (int e = 0; e < 2; e++) begin
      ddtm_host_model_inst.issue(K_MRS, 3'h0, 14'h0032 | (14'(slow) << 12), 12);
      settle2();
      check(o_slow_exit, slow, "exit select");
      if (open) ddtm_host_model_inst.issue(K_ACT, 3'h2, 14'h0000, 4);
      ddtm_host_model_inst.set_cke(1'b0, sref, 4, 1'b0);
      settle2();
      check(8'({o_self_refresh, o_power_down}), sref ? 8'h02 : 8'h01, "power state");
      ddtm_host_model_inst.set_cke(1'b1, 1'b0, 1, 1'b0);
      ddtm_host_model_inst.issue(c2, 3'h2, 14'h0000, e == 0 ? lim - 1 : lim + slack());
      settle2();
      check(o_violation, e == 0, "exit spacing");
      ddtm_host_model_inst.issue(K_PRE, 3'h0, 14'h0400, 210);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_reset = 1'b0;
    check(8'(o_violation), 8'h00, "reset violation");
    check(o_bank_open, 8'h00, "reset banks");
    check(8'({o_cal_drive_oe_n, o_odt_sync_ok}), 8'h03, "reset outputs");
    repeat (6) @(negedge i_clk_sys);
    ddtm_host_model_inst.set_cke(1'b1, 1'b0, 1, 1'b0);
    for (int e = 0; e < 2; e++) begin
      pair(K_ACT, K_ACT, int'(RRD_CYC), 1'b0, e == 0);
      pair(K_RD, K_RD, int'(CCD_CYC), 1'b1, e == 0);
      pair(K_WR, K_WR, int'(CCD_CYC), 1'b1, e == 0);
      pair(K_WR, K_RD, WEND + int'(WTR_CYC), 1'b1, e == 0);
      pair(K_RD, K_PRE, (2 > int'(RTP_CYC)) ? 2 : int'(RTP_CYC), 1'b1, e == 0);
      pair(K_WR, K_PRE, WEND + int'(WR_CYC), 1'b1, e == 0);
      pair(K_PRE, K_ACT, int'(RP_CYC), 1'b1, e == 0);
    end
    // five activates at the legal gap: the fifth lands exactly when the window ends
    for (int j = 0; j < 5; j++) begin
      ddtm_host_model_inst.issue(K_ACT, 3'(j), 14'h0000, j == 0 ? 12 : int'(RRD_CYC));
    end
    settle2();
    check(o_violation, 1'b0, "fifth activate at window end");
    check(o_bank_open, 8'h1F, "window banks open");
    ddtm_host_model_inst.issue(K_PRE, 3'h0, 14'h0400, 12);
    // auto-precharge write closes the bank by itself
    ddtm_host_model_inst.issue(K_ACT, 3'h5, 14'h0123, 12);
    settle2();
    check(o_bank_open, 8'h20, "bank open");
    ddtm_host_model_inst.issue(K_WR, 3'h5, 14'h0400, 8);
    k = 0;
    while (k < 20 && o_int_precharge[5] !== 1'b1) begin
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      k++;
    end
    check(8'(k), 8'h09, "auto precharge time");
    @(negedge i_clk_sys);
    check(o_bank_open, 8'h00, "bank closed");
    pdx(1'b0, 1'b0, 1'b0, K_ACT, int'(XP_CYC));
    pdx(1'b0, 1'b1, 1'b0, K_RD, int'(XARD_CYC));
    pdx(1'b0, 1'b1, 1'b1, K_RD, int'(XARDS_BASE) - 0);
    pdx(1'b1, 1'b1, 1'b0, K_RD, int'(XSRD_CYC));
    pdx(1'b1, 1'b0, 1'b0, K_ACT, int'(XSNR_CYC));
    for (int g = 2; g < 4; g++) begin
      ddtm_host_model_inst.set_cke(1'b0, 1'b0, 4, 1'b0);
      ddtm_host_model_inst.set_cke(1'b1, 1'b0, g, 1'b1);
      settle2();
      check(o_violation, g < 3, "enable pulse");
    end
    for (int g = 3; g < 5; g++) begin
      ddtm_host_model_inst.set_odt(~odt, 6);
      ddtm_host_model_inst.set_cke(1'b0, 1'b0, g, 1'b0);
      settle2();
      check(o_violation, g < int'(ANPD_CYC), "termination to power-down");
      ddtm_host_model_inst.set_cke(1'b1, 1'b0, 3, 1'b0);
      repeat (4) @(negedge i_clk_sys);
      check(o_odt_sync_ok, 1'b0, "termination not yet synchronous");
      repeat (10) @(negedge i_clk_sys);
      check(o_odt_sync_ok, 1'b1, "termination synchronous");
    end
    for (int i = 0; i < 3; i++) begin
      ocd = (i == 0) ? OCD_DRIVE1 : (i == 1) ? OCD_DRIVE0 : 3'h0;
      q = 1'($random(seed));
      ddtm_host_model_inst.issue(K_MRS, 3'h1, (14'(q) << 10) | (14'(ocd) << 7), 12);
      repeat (6) @(negedge i_clk_sys);
      check(o_dqs_single_ended, q, "strobe mode");
      check(o_cal_drive_oe_n, i == 2, "calibration drive enable");
      if (i < 2) check(o_cal_drive_level, i == 0, "calibration level");
    end
    final_report();
  end
endmodule
`default_nettype wire
